// >>> core/port_parity_timeout_error_regs.sv
// per-port parity error and tlp time-out error registers behind an apb slave
//
// Function
// - hardware sets parity error flag bit 0 on detected error; write one clears.
// - each zero-to-one change of the parity flag issues one error report unless the report field is 0.
// - report field 0 none, 1 correctable, 2 nonfatal, 3 fatal message.
// - every detected parity error adds one to the 8-bit tally.
// - the tally saturates at its maximum and never wraps to zero.
// - reading the tally returns its value then clears it.
// - posted queue discard for age sets time-out status bit 0; write one clears.
// - non-posted queue discard for age sets status bit 1; write one clears.
// - completion queue discard for age sets status bit 2; write one clears.
// - insertion queue discard for age sets status bit 3; write one clears.
// - parity check disable suppresses all parity errors; outgoing parity unaffected.
// - a tlp older than the fixed age limit is timed out and discarded.
`timescale 1ns/1ps
module port_parity_timeout_error_regs
  import err_regs_pkg::*;
#(
  parameter int unsigned AGE_LIMIT_CYCLES = TLP_AGE_LIMIT_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic parity_err_detect,
  input wire logic [3:0] queue_head_waiting,
  input wire logic [3:0] queue_head_advance,
  output logic [3:0] queue_discard,
  output logic err_msg_valid,
  output logic [1:0] err_msg_type
);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  typedef enum logic [6:0] {
    SEL_NONE = 7'b0000001,
    SEL_CHECK = 7'b0000010,
    SEL_PSTAT = 7'b0000100,
    SEL_REPORT = 7'b0001000,
    SEL_TALLY = 7'b0010000,
    SEL_TOCTL = 7'b0100000,
    SEL_TOSTAT = 7'b1000000
  } reg_sel_t;

  function automatic reg_sel_t decode(input logic [11:0] addr);
    reg_sel_t sel;
    unique case (addr)
      PARITY_CHECK_CONTROL_OFF: sel = SEL_CHECK;
      PARITY_ERROR_STATUS_OFF: sel = SEL_PSTAT;
      PARITY_ERROR_REPORT_CONTROL_OFF: sel = SEL_REPORT;
      PARITY_ERROR_COUNTER_OFF: sel = SEL_TALLY;
      TIMEOUT_CONTROL_OFF: sel = SEL_TOCTL;
      TIMEOUT_STATUS_OFF: sel = SEL_TOSTAT;
      default: sel = SEL_NONE;
    endcase
    return sel;
  endfunction

  logic parity_check_disable_reg;
  logic parity_err_flag_reg;
  logic [1:0] report_control_reg;
  logic [7:0] parity_err_tally_reg;
  logic timeout_enable_bit_reg;
  logic posted_queue_timeout_reg;
  logic nonposted_queue_timeout_reg;
  logic completion_queue_timeout_reg;
  logic insertion_queue_timeout_reg;
  logic [3:0] timeout_status;
  logic [AGE_W-1:0] age_reg [NUM_QUEUES];
  logic [3:0] discard_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic msg_valid_reg;
  logic [1:0] msg_type_reg;

  reg_sel_t sel;
  logic setup_done;
  logic commit;
  logic wr_commit;
  logic rd_take;
  logic parity_event;
  logic [AGE_W-1:0] age_limit;

  assign sel = decode(paddr);
  // one wait state: data is captured in the first access cycle, pready follows
  assign setup_done = psel & penable & ~pready_reg;
  assign commit = psel & penable & pready_reg;
  assign wr_commit = commit & pwrite;
  // read side effect rides on the capture edge so an error arriving between
  // capture and completion cannot be swallowed by the clear
  assign rd_take = setup_done & ~pwrite;
  assign parity_event = parity_err_detect & ~parity_check_disable_reg;
  assign age_limit = AGE_W'(AGE_LIMIT_CYCLES);

  // ---------------------------------------------------------------
  // per-register write and read strobes
  // ---------------------------------------------------------------
  logic wr_check;
  logic wr_pstat;
  logic wr_report;
  logic wr_toctl;
  logic wr_tostat;
  logic tally_read;

  assign wr_check = wr_commit & (sel == SEL_CHECK);
  assign wr_pstat = wr_commit & (sel == SEL_PSTAT);
  assign wr_report = wr_commit & (sel == SEL_REPORT);
  assign wr_toctl = wr_commit & (sel == SEL_TOCTL);
  assign wr_tostat = wr_commit & (sel == SEL_TOSTAT);
  // tally clear shares the capture edge with prdata
  assign tally_read = rd_take & (sel == SEL_TALLY);

  // ---------------------------------------------------------------
  // apb handshake and read data
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup_done;
      pslverr_reg <= setup_done & (sel == SEL_NONE);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata_reg <= 32'h00000000;
    end else if (rd_take) begin
      unique case (sel)
        SEL_CHECK: prdata_reg <= {31'h0, parity_check_disable_reg};
        SEL_PSTAT: prdata_reg <= {31'h0, parity_err_flag_reg};
        SEL_REPORT: prdata_reg <= {30'h0, report_control_reg};
        SEL_TALLY: prdata_reg <= {24'h0, parity_err_tally_reg};
        SEL_TOCTL: prdata_reg <= {31'h0, timeout_enable_bit_reg};
        SEL_TOSTAT: prdata_reg <= {28'h0, timeout_status};
        SEL_NONE: prdata_reg <= 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // software controls
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      parity_check_disable_reg <= PARITY_CHECK_DISABLE_RST;
    end else if (wr_check) begin
      parity_check_disable_reg <= pwdata[PARITY_CHECK_DISABLE_BIT];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      report_control_reg <= REPORT_CONTROL_RST;
    end else if (wr_report) begin
      report_control_reg <= pwdata[REPORT_FIELD_W-1:0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      timeout_enable_bit_reg <= TIMEOUT_ENABLE_RST;
    end else if (wr_toctl) begin
      timeout_enable_bit_reg <= pwdata[TIMEOUT_ENABLE_BIT];
    end
  end

  // ---------------------------------------------------------------
  // parity error flag, tally and report
  // ---------------------------------------------------------------
  // a detected error in the clearing cycle keeps the flag set
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      parity_err_flag_reg <= PARITY_ERR_FLAG_RST;
    end else if (parity_event) begin
      parity_err_flag_reg <= 1'b1;
    end else if (wr_pstat && pwdata[PARITY_ERR_FLAG_BIT]) begin
      parity_err_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      parity_err_tally_reg <= TALLY_RST;
    end else if (tally_read) begin
      // an error in the read cycle starts the fresh count at one
      parity_err_tally_reg <= parity_event ? 8'h01 : TALLY_RST;
    end else if (parity_event && parity_err_tally_reg != TALLY_MAX) begin
      parity_err_tally_reg <= parity_err_tally_reg + 8'h01;
    end
  end

  // a report goes out only on the flag's rising edge; repeats while set are silent
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      msg_valid_reg <= 1'b0;
      msg_type_reg <= REPORT_NONE;
    end else begin
      msg_valid_reg <= 1'b0;
      if (parity_event && !parity_err_flag_reg && report_control_reg != REPORT_NONE) begin
        msg_valid_reg <= 1'b1;
        msg_type_reg <= report_control_reg;
      end
    end
  end

  // ---------------------------------------------------------------
  // input queue ageing
  // ---------------------------------------------------------------
  // the age restarts whenever a new tlp reaches the head or one is discarded
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int q = 0; q < NUM_QUEUES; q++) begin
        age_reg[q] <= '0;
      end
      discard_reg <= 4'h0;
    end else begin
      for (int q = 0; q < NUM_QUEUES; q++) begin
        discard_reg[q] <= 1'b0;
        if (!timeout_enable_bit_reg || !queue_head_waiting[q] || queue_head_advance[q]) begin
          age_reg[q] <= '0;
        end else if (age_reg[q] >= age_limit) begin
          discard_reg[q] <= 1'b1;
          age_reg[q] <= '0;
        end else begin
          age_reg[q] <= age_reg[q] + AGE_W'(1);
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // time-out status
  // ---------------------------------------------------------------
  logic [3:0] to_clear;
  assign to_clear = wr_tostat ? pwdata[3:0] : 4'h0;

  // set wins over a same-cycle clear, so a discard is never lost to software
  function automatic logic sticky_next(input logic cur, input logic set, input logic clr);
    return set | (cur & ~clr);
  endfunction

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      posted_queue_timeout_reg <= TIMEOUT_STATUS_RST[POSTED_QUEUE_TIMEOUT_BIT];
    end else begin
      posted_queue_timeout_reg <= sticky_next(posted_queue_timeout_reg,
        discard_reg[POSTED_QUEUE_TIMEOUT_BIT],
        to_clear[POSTED_QUEUE_TIMEOUT_BIT]);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      nonposted_queue_timeout_reg <= TIMEOUT_STATUS_RST[NONPOSTED_QUEUE_TIMEOUT_BIT];
    end else begin
      nonposted_queue_timeout_reg <= sticky_next(nonposted_queue_timeout_reg,
        discard_reg[NONPOSTED_QUEUE_TIMEOUT_BIT],
        to_clear[NONPOSTED_QUEUE_TIMEOUT_BIT]);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      completion_queue_timeout_reg <= TIMEOUT_STATUS_RST[COMPLETION_QUEUE_TIMEOUT_BIT];
    end else begin
      completion_queue_timeout_reg <= sticky_next(completion_queue_timeout_reg,
        discard_reg[COMPLETION_QUEUE_TIMEOUT_BIT],
        to_clear[COMPLETION_QUEUE_TIMEOUT_BIT]);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      insertion_queue_timeout_reg <= TIMEOUT_STATUS_RST[INSERTION_QUEUE_TIMEOUT_BIT];
    end else begin
      insertion_queue_timeout_reg <= sticky_next(insertion_queue_timeout_reg,
        discard_reg[INSERTION_QUEUE_TIMEOUT_BIT],
        to_clear[INSERTION_QUEUE_TIMEOUT_BIT]);
    end
  end

  always_comb begin
    timeout_status = TIMEOUT_STATUS_RST;
    timeout_status[POSTED_QUEUE_TIMEOUT_BIT] = posted_queue_timeout_reg;
    timeout_status[NONPOSTED_QUEUE_TIMEOUT_BIT] = nonposted_queue_timeout_reg;
    timeout_status[COMPLETION_QUEUE_TIMEOUT_BIT] = completion_queue_timeout_reg;
    timeout_status[INSERTION_QUEUE_TIMEOUT_BIT] = insertion_queue_timeout_reg;
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign queue_discard = discard_reg;
  assign err_msg_valid = msg_valid_reg;
  assign err_msg_type = msg_type_reg;

endmodule

// >>> core/err_regs_pkg.sv
// constants for the per-port parity and time-out error registers
package err_regs_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] PARITY_CHECK_CONTROL_OFF = 12'h740;
  localparam logic [11:0] PARITY_ERROR_STATUS_OFF = 12'h744;
  localparam logic [11:0] PARITY_ERROR_REPORT_CONTROL_OFF = 12'h748;
  localparam logic [11:0] PARITY_ERROR_COUNTER_OFF = 12'h74c;
  localparam logic [11:0] TIMEOUT_CONTROL_OFF = 12'h750;
  localparam logic [11:0] TIMEOUT_STATUS_OFF = 12'h754;

  // ---------------------------------------------------------------
  // field positions and widths
  // ---------------------------------------------------------------
  localparam int PARITY_CHECK_DISABLE_BIT = 0;
  localparam int PARITY_ERR_FLAG_BIT = 0;
  localparam int REPORT_FIELD_W = 2;
  localparam int TALLY_W = 8;
  localparam int TIMEOUT_ENABLE_BIT = 0;
  localparam int POSTED_QUEUE_TIMEOUT_BIT = 0;
  localparam int NONPOSTED_QUEUE_TIMEOUT_BIT = 1;
  localparam int COMPLETION_QUEUE_TIMEOUT_BIT = 2;
  localparam int INSERTION_QUEUE_TIMEOUT_BIT = 3;
  localparam int NUM_QUEUES = 4;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic PARITY_CHECK_DISABLE_RST = 1'h0;
  localparam logic PARITY_ERR_FLAG_RST = 1'h0;
  localparam logic [1:0] REPORT_CONTROL_RST = 2'h2;
  localparam logic [7:0] TALLY_RST = 8'h00;
  localparam logic [7:0] TALLY_MAX = 8'hff;
  localparam logic TIMEOUT_ENABLE_RST = 1'h1;
  localparam logic [3:0] TIMEOUT_STATUS_RST = 4'h0;

  // ---------------------------------------------------------------
  // error message encodings sent toward the root
  // ---------------------------------------------------------------
  localparam logic [1:0] REPORT_NONE = 2'h0;
  localparam logic [1:0] REPORT_COR = 2'h1;
  localparam logic [1:0] REPORT_NONFATAL = 2'h2;
  localparam logic [1:0] REPORT_FATAL = 2'h3;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_FREQ_KHZ = 250000;
  localparam int TLP_AGE_LIMIT_MS = 50;
  localparam int unsigned TLP_AGE_LIMIT_CYCLES = TLP_AGE_LIMIT_MS * CLK_FREQ_KHZ;
  localparam int AGE_W = 24;

endpackage

// >>> bench/root_model.sv
// behavioural root complex collecting the port's error messages
`timescale 1ns/1ps
module root_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic err_msg_valid,
  input wire logic [1:0] err_msg_type
);
  // one count per message type, so a wrong type shows as a wrong count
  int msg_count [4];
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      foreach (msg_count[i]) msg_count[i] <= 0;
    end else if (err_msg_valid === 1'b1) begin
      msg_count[err_msg_type] <= msg_count[err_msg_type] + 1;
    end
  end
endmodule

// >>> bench/port_err_regs_monitor.sv
// assertion checker for the port parity and time-out error registers
`timescale 1ns/1ps
module port_err_regs_monitor
  import err_regs_pkg::*;
#(
  parameter int unsigned AGE_LIMIT_CYCLES = 20
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic parity_err_detect,
  input wire logic [3:0] queue_head_waiting,
  input wire logic [3:0] queue_head_advance,
  input wire logic [3:0] queue_discard,
  input wire logic err_msg_valid,
  input wire logic [1:0] err_msg_type
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  chk_msg_type_set: assert property (err_msg_valid |-> err_msg_type != REPORT_NONE)
    else $error("message with type none");
  chk_msg_has_cause: assert property (err_msg_valid |-> $past(parity_err_detect))
    else $error("message without parity error");
  chk_msg_one_shot: assert property (err_msg_valid |=> !err_msg_valid)
    else $error("message repeated");
  chk_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("ready not in second access cycle");
  chk_slverr_ready: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
    else $error("slave error without ready or with data");
  chk_discard_pulse: assert property (|queue_discard |=> (queue_discard & $past(queue_discard)) == 4'h0)
    else $error("discard longer than one cycle");
  chk_discard_waiting: assert property ((queue_discard & ~$past(queue_head_waiting)) == 4'h0)
    else $error("discard of an empty queue");
  chk_discard_fresh: assert property ((queue_discard & $past(queue_head_advance)) == 4'h0)
    else $error("discard right after head advanced");
  cover property (err_msg_valid && err_msg_type == REPORT_FATAL);
  cover property (queue_discard[3]);
  cover property (pslverr);
endmodule

bind port_parity_timeout_error_regs port_err_regs_monitor #(.AGE_LIMIT_CYCLES(AGE_LIMIT_CYCLES))
  mon_u (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .parity_err_detect(parity_err_detect), .queue_head_waiting(queue_head_waiting),
  .queue_head_advance(queue_head_advance), .queue_discard(queue_discard),
  .err_msg_valid(err_msg_valid), .err_msg_type(err_msg_type));

// >>> bench/tb.sv
// self-checking bench for the port parity and time-out error registers
`timescale 1ns/1ps
module tb
  import err_regs_pkg::*;
;
  // short age limit keeps the time-out runs brief
  localparam int AGE = 20;
  logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, parity_err_detect = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic pready, pslverr, err_msg_valid, err;
  logic [1:0] err_msg_type;
  logic [3:0] queue_head_waiting = 4'h0, queue_head_advance = 4'h0, queue_discard;
  int miscompares = 0, checks = 0;
  initial forever #2 mclk = ~mclk;
  port_parity_timeout_error_regs #(.AGE_LIMIT_CYCLES(AGE)) dut_u (.mclk(mclk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .parity_err_detect(parity_err_detect),
    .queue_head_waiting(queue_head_waiting), .queue_head_advance(queue_head_advance),
    .queue_discard(queue_discard), .err_msg_valid(err_msg_valid), .err_msg_type(err_msg_type));
  root_model root_u (.mclk(mclk), .rst(rst), .err_msg_valid(err_msg_valid),
    .err_msg_type(err_msg_type));
  task finish_test();
    if (miscompares == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask
  // one apb transfer; the first edge keeps back-to-back calls from double-driving psel
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      $display("unexpected pready expected 1 seen %b", pready);
      miscompares++;
      finish_test();
    end
  endtask
  task rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp($sformatf("read %h", a), exp, rdata);
  endtask
  task errs(input int n);
    @(posedge mclk);
    parity_err_detect <= 1'b1;
    repeat (n) @(posedge mclk);
    parity_err_detect <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task t_reset();
    rchk(PARITY_CHECK_CONTROL_OFF, 32'h0);
    rchk(PARITY_ERROR_STATUS_OFF, 32'h0);
    rchk(PARITY_ERROR_REPORT_CONTROL_OFF, 32'h2);
    rchk(TIMEOUT_CONTROL_OFF, 32'h1);
    rchk(TIMEOUT_STATUS_OFF, 32'h0);
    apb(1'b1, PARITY_ERROR_REPORT_CONTROL_OFF, 32'hffff_fffd);
    rchk(PARITY_ERROR_REPORT_CONTROL_OFF, 32'h1);
    apb(1'b0, 12'h7fc, 32'h0);
    cmp("unmapped error", 32'h1, {31'h0, err});
    cmp("unmapped read", 32'h0, rdata);
  endtask
  task t_report();
    int total;
    for (int t = 0; t < 4; t++) begin
      apb(1'b1, PARITY_ERROR_REPORT_CONTROL_OFF, 32'(t));
      errs(1);
      errs(1);
      total = root_u.msg_count[0] + root_u.msg_count[1];
      total += root_u.msg_count[2] + root_u.msg_count[3];
      cmp("message count", (t == 0) ? 32'h0 : 32'h1, root_u.msg_count[t]);
      cmp("messages sent", 32'(t), 32'(total));
      rchk(PARITY_ERROR_STATUS_OFF, 32'h1);
      apb(1'b1, PARITY_ERROR_STATUS_OFF, 32'hffff_ffff);
      rchk(PARITY_ERROR_STATUS_OFF, 32'h0);
    end
  endtask
  task t_tally();
    rchk(PARITY_ERROR_COUNTER_OFF, 32'h8);
    rchk(PARITY_ERROR_COUNTER_OFF, 32'h0);
    errs(300);
    rchk(PARITY_ERROR_COUNTER_OFF, 32'hff);
    apb(1'b1, PARITY_ERROR_STATUS_OFF, 32'h1);
    apb(1'b1, PARITY_CHECK_CONTROL_OFF, 32'h1);
    errs(4);
    rchk(PARITY_ERROR_COUNTER_OFF, 32'h0);
    rchk(PARITY_ERROR_STATUS_OFF, 32'h0);
    apb(1'b1, PARITY_CHECK_CONTROL_OFF, 32'h0);
  endtask
  task t_timeout();
    int n;
    for (int q = 0; q < NUM_QUEUES; q++) begin
      queue_head_waiting <= 4'(1 << q);
      n = 0;
      do begin
        @(posedge mclk);
        n++;
      end while (queue_discard[q] !== 1'b1 && n < 4 * AGE);
      if (queue_discard[q] !== 1'b1) begin
        $display("unexpected discard expected 1 seen %b", queue_discard[q]);
        miscompares++;
        finish_test();
      end
      // pulse shows after AGE+1 edges and is seen at the next one
      cmp("discard delay", 32'(AGE + 2), 32'(n));
      queue_head_waiting <= 4'h0;
      rchk(TIMEOUT_STATUS_OFF, 32'(1 << q));
      apb(1'b1, TIMEOUT_STATUS_OFF, 32'hf);
    end
    queue_head_waiting <= 4'hf;
    n = 0;
    for (int i = 0; i < 3 * AGE; i++) begin
      queue_head_advance <= (i % 8 == 0) ? 4'hf : 4'h0;
      @(posedge mclk);
      if (queue_discard !== 4'h0) n++;
    end
    queue_head_advance <= 4'h0;
    queue_head_waiting <= 4'h0;
    cmp("discards with moving heads", 32'h0, 32'(n));
    apb(1'b1, TIMEOUT_CONTROL_OFF, 32'h0);
    queue_head_waiting <= 4'hf;
    n = 0;
    repeat (3 * AGE) begin
      @(posedge mclk);
      if (queue_discard !== 4'h0) n++;
    end
    cmp("disabled discards", 32'h0, 32'(n));
    queue_head_waiting <= 4'h0;
    rchk(TIMEOUT_STATUS_OFF, 32'h0);
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_report();
    t_tally();
    t_timeout();
    finish_test();
  end
endmodule
